// [hdl/lutx_baud.sv]
// Purpose: fractional bit-period tick generator
// Assumes: divider value in 1/256 units, low three bits zero
// Notes:   restart realigns the bit period to a frame start
`include "lutx_defines.svh"
module lutx_baud
    import lutx_pkg::*;
#(
    parameter int DIV_W = 14
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             restart,
    input  wire logic [DIV_W+2:0] divider,
    output logic                  tick
);
    localparam int ACC_W = DIV_W + 4;
    if (DIV_W != 14) begin : g_div_check
        $error("lutx_baud: divider must be 14 bits");
    end
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] period;
    // period = 256 + divider; accumulator steps 256 (one whole clock) per input clock
    assign period = ACC_W'(`LUTX_FRAC_ONE) + ACC_W'(divider);
    // average rate exact by carrying the remainder
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            tick    <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                // preload one step: tick is registered, else start bit runs a clock long
                acc_reg <= ACC_W'(`LUTX_FRAC_ONE);
                tick    <= 1'b0;
            end else if (acc_reg + ACC_W'(`LUTX_FRAC_ONE) >= period) begin
                acc_reg <= acc_reg + ACC_W'(`LUTX_FRAC_ONE) - period;
                tick    <= 1'b1;
            end else begin
                acc_reg <= acc_reg + ACC_W'(`LUTX_FRAC_ONE);
                tick    <= 1'b0;
            end
        end
    end
endmodule : lutx_baud

// [hdl/lutx_defines.svh]
// Purpose: constants for the low-energy serial transmitter block
// Assumes: APB slave, 32-bit words, byte offsets multiple of four
// Notes:   offsets, fields and constants used by the design files
`ifndef LUTX_DEFINES_SVH
`define LUTX_DEFINES_SVH
`define LUTX_ADDR_W        8
`define LUTX_OFF_CTRL      8'h00
`define LUTX_OFF_CMD       8'h04
`define LUTX_OFF_STATUS    8'h08
`define LUTX_OFF_CLKDIV    8'h0C
`define LUTX_OFF_IF        8'h10
`define LUTX_OFF_IFC       8'h14
`define LUTX_OFF_TXDATA    8'h18
`define LUTX_OFF_TXDATAX   8'h1C
`define LUTX_CTRL_WORD9    0
`define LUTX_CTRL_PAR_LO   2
`define LUTX_CTRL_PAR_HI   3
`define LUTX_CTRL_STOP2    4
`define LUTX_CTRL_FLIP     5
`define LUTX_CTRL_BIT8DEF  6
`define LUTX_CTRL_W        7
`define LUTX_CMD_ON        0
`define LUTX_CMD_OFF       1
`define LUTX_ST_ON         0
`define LUTX_ST_DONE       1
`define LUTX_ST_LEVEL      2
`define LUTX_IF_DONE       0
`define LUTX_IF_LEVEL      1
`define LUTX_IF_OVF        2
`define LUTX_DIV_HI        16
`define LUTX_DIV_LO        3
`define LUTX_FRAC_ONE      12'h100
`define LUTX_PAR_EVEN      2'h2
`define LUTX_PAR_ODD       2'h3
`endif

// [hdl/lutx_pkg.sv]
// Purpose: types shared by the transmitter files
// Assumes: nothing
// Notes:   one-hot state codes
package lutx_pkg;
    typedef enum logic [4:0] {
        LUTX_IDLE   = 5'b00001,
        LUTX_START  = 5'b00010,
        LUTX_DATA   = 5'b00100,
        LUTX_PARITY = 5'b01000,
        LUTX_STOP   = 5'b10000
    } lutx_state_e;
    typedef logic [8:0] lutx_word_t;
endpackage : lutx_pkg

// [hdl/lutx_shift.sv]
// Purpose: frame serialiser for one buffered word
// Assumes: settings stable during a frame
// Notes:   line output is the uninverted level; top flips it
`include "lutx_defines.svh"
module lutx_shift
    import lutx_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       abort,
    input  wire logic       tick,
    input  wire logic       load,
    input  wire lutx_word_t word,
    input  wire logic       word9,
    input  wire logic [1:0] parity_sel,
    input  wire logic       stop2,
    output logic            busy,
    output logic            frame_end,
    output logic            line
);
    lutx_state_e state_reg;
    lutx_word_t  sh_reg;
    logic [3:0]  cnt_reg;
    logic        par_reg;
    logic        pen;
    assign pen  = parity_sel[1];
    assign busy = (state_reg != LUTX_IDLE);
    function automatic logic par_of(input lutx_word_t w, input logic nine,
                                    input logic odd);
        par_of = (^w[7:0]) ^ (nine & w[8]) ^ odd;
    endfunction : par_of
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= LUTX_IDLE;
            sh_reg    <= '0;
            cnt_reg   <= '0;
            par_reg   <= 1'b0;
            line      <= 1'b1;
            frame_end <= 1'b0;
        end else if (ce) begin
            frame_end <= 1'b0;
            if (abort) begin
                state_reg <= LUTX_IDLE;
                line      <= 1'b1;
            end else begin
                case (state_reg)
                LUTX_IDLE: begin
                    if (load) begin
                        sh_reg    <= word;
                        // parity for even/odd count of ones
                        par_reg   <= par_of(word, word9, parity_sel == `LUTX_PAR_ODD);
                        state_reg <= LUTX_START;
                        line      <= 1'b0;   // start bit, one period
                    end
                end
                LUTX_START: begin
                    if (tick) begin
                        line      <= sh_reg[0];
                        cnt_reg   <= '0;
                        state_reg <= LUTX_DATA;
                    end
                end
                LUTX_DATA: begin
                    if (tick) begin
                        // 8 or 9 data bits
                        if (cnt_reg == (word9 ? 4'h8 : 4'h7)) begin
                            cnt_reg <= '0;
                            if (pen) begin
                                line      <= par_reg;
                                state_reg <= LUTX_PARITY;
                            end else begin
                                line      <= 1'b1;
                                state_reg <= LUTX_STOP;
                            end
                        end else begin
                            sh_reg  <= {1'b0, sh_reg[8:1]};
                            line    <= sh_reg[1];
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                LUTX_PARITY: begin
                    if (tick) begin
                        line      <= 1'b1;
                        state_reg <= LUTX_STOP;
                    end
                end
                LUTX_STOP: begin
                    if (tick) begin
                        // one or two stop bits
                        if (cnt_reg == (stop2 ? 4'h1 : 4'h0)) begin
                            frame_end <= 1'b1;
                            if (load) begin
                                // back to back, no gap
                                sh_reg    <= word;
                                par_reg   <= par_of(word, word9,
                                                    parity_sel == `LUTX_PAR_ODD);
                                line      <= 1'b0;
                                state_reg <= LUTX_START;
                            end else begin
                                state_reg <= LUTX_IDLE;
                            end
                            cnt_reg <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                default: state_reg <= LUTX_IDLE;
                endcase
            end
        end
    end
endmodule : lutx_shift

// [hdl/lutx_top.sv]
// Purpose: low-energy serial transmitter with APB register file
// Assumes: single clock, APB answers with zero wait states
// Notes:   receiver not present; polarity flip applies to output only
//
// The APB slave port and the address map were left to the implementer.
`include "lutx_defines.svh"
module lutx_top
    import lutx_pkg::*;
#(
    parameter int DIV_W = 14
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             TX_LINE
);
    if (DIV_W != 14) begin : g_div_check
        $error("lutx_top: divider must be 14 bits");
    end
    logic [`LUTX_CTRL_W-1:0]   ctrl_reg;
    logic [DIV_W+2:0]          div_reg;
    logic                      on_reg;
    logic                      done_reg;
    logic [2:0]                flag_reg;
    lutx_word_t                buf_reg;
    logic                      full_reg;
    logic                      wr_acc;
    logic                      rd_acc;
    logic                      data_wr;
    logic                      cmd_wr;
    logic                      tick;
    logic                      busy;
    logic                      frame_end;
    logic                      line;
    logic                      load;
    logic                      abort;
    logic                      flip_line;
    logic                      word9;
    lutx_word_t                wr_word;
    logic                      taken;
    assign wr_acc  = PSEL && PENABLE && PWRITE;
    assign rd_acc  = PSEL && !PENABLE && !PWRITE;
    assign data_wr = wr_acc && (PADDR == `LUTX_OFF_TXDATA || PADDR == `LUTX_OFF_TXDATAX);
    assign cmd_wr  = wr_acc && (PADDR == `LUTX_OFF_CMD);
    assign word9   = ctrl_reg[`LUTX_CTRL_WORD9];
    // ninth bit from default on 8-bit write, given on extended write
    assign wr_word = (PADDR == `LUTX_OFF_TXDATAX) ? PWDATA[8:0]
                   : {ctrl_reg[`LUTX_CTRL_BIT8DEF], PWDATA[7:0]};
    // shifter takes the buffer only while enabled
    assign load    = on_reg && full_reg;
    assign abort   = cmd_wr && PWDATA[`LUTX_CMD_OFF];
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `LUTX_OFF_CTRL) || (a == `LUTX_OFF_CMD) ||
                    (a == `LUTX_OFF_STATUS) || (a == `LUTX_OFF_CLKDIV) ||
                    (a == `LUTX_OFF_IF) || (a == `LUTX_OFF_IFC) ||
                    (a == `LUTX_OFF_TXDATA) || (a == `LUTX_OFF_TXDATAX);
    endfunction : is_mapped
    lutx_baud #(
        .DIV_W   (DIV_W)
    ) u_baud (
        .clock   (CLOCK),
        .rst_n   (RST_N),
        .ce      (CE),
        .restart (!busy),
        .divider (div_reg),
        .tick    (tick)
    );
    lutx_shift u_shift (
        .clock      (CLOCK),
        .rst_n      (RST_N),
        .ce         (CE),
        .abort      (abort),
        .tick       (tick),
        .load       (load),
        .word       (buf_reg),
        .word9      (word9),
        .parity_sel (ctrl_reg[`LUTX_CTRL_PAR_HI:`LUTX_CTRL_PAR_LO]),
        .stop2      (ctrl_reg[`LUTX_CTRL_STOP2]),
        .busy       (busy),
        .frame_end  (frame_end),
        .line       (line)
    );
    // buffer empties on an idle load, or on a reload seen one clock later
    // as frame_end with the shifter still busy
    assign taken = (load && !busy) || (frame_end && busy);
    // control and divider words
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= '0;   // parity off by default
            div_reg  <= '0;
        end else if (CE && wr_acc) begin
            if (PADDR == `LUTX_OFF_CTRL) begin
                ctrl_reg <= PWDATA[`LUTX_CTRL_W-1:0];
            end
            if (PADDR == `LUTX_OFF_CLKDIV) begin
                // 9.5 fixed point, low three bits forced zero
                div_reg <= {PWDATA[`LUTX_DIV_HI:`LUTX_DIV_LO], 3'h0};
            end
        end
    end
    // one-shot on/off; off wins when both are written
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            on_reg <= 1'b0;
        end else if (CE && cmd_wr) begin
            if (PWDATA[`LUTX_CMD_OFF]) begin
                on_reg <= 1'b0;
            end else if (PWDATA[`LUTX_CMD_ON]) begin
                on_reg <= 1'b1;
            end
        end
    end
    // single-word transmit buffer
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            buf_reg  <= '0;
            full_reg <= 1'b0;
        end else if (CE) begin
            if (data_wr && !full_reg) begin
                buf_reg  <= wr_word;
                full_reg <= 1'b1;
            end else if (taken) begin
                full_reg <= 1'b0;
            end
        end
    end
    // status and sticky flags; hardware set wins over IFC clear, a data write wins over done set
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            done_reg <= 1'b0;
            flag_reg <= '0;
        end else if (CE) begin
            if (data_wr && !full_reg) begin
                done_reg <= 1'b0;
            end else if (frame_end && !full_reg) begin
                done_reg <= 1'b1;
            end
            if (frame_end && !full_reg) begin
                flag_reg[`LUTX_IF_DONE] <= 1'b1;
            end else if (wr_acc && PADDR == `LUTX_OFF_IFC && PWDATA[`LUTX_IF_DONE]) begin
                flag_reg[`LUTX_IF_DONE] <= 1'b0;
            end
            if (data_wr && full_reg) begin
                flag_reg[`LUTX_IF_OVF] <= 1'b1;
            end else if (wr_acc && PADDR == `LUTX_OFF_IFC && PWDATA[`LUTX_IF_OVF]) begin
                flag_reg[`LUTX_IF_OVF] <= 1'b0;
            end
            if (data_wr && !full_reg) begin
                flag_reg[`LUTX_IF_LEVEL] <= 1'b0;
            end else if (taken) begin
                flag_reg[`LUTX_IF_LEVEL] <= 1'b1;
            end else if (wr_acc && PADDR == `LUTX_OFF_IFC && PWDATA[`LUTX_IF_LEVEL]) begin
                flag_reg[`LUTX_IF_LEVEL] <= 1'b0;
            end
        end
    end
    // line output; flipped polarity inverts every bit and the idle level
    assign flip_line = ctrl_reg[`LUTX_CTRL_FLIP] ? ~line : line;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            TX_LINE <= 1'b1;
        end else if (CE) begin
            TX_LINE <= flip_line;
        end
    end
    // apb answer: zero wait, error on unmapped address
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA  <= '0;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !is_mapped(PADDR);
            PRDATA  <= '0;
            if (rd_acc) begin
                case (PADDR)
                `LUTX_OFF_CTRL:   PRDATA <= 32'(ctrl_reg);
                `LUTX_OFF_CLKDIV: PRDATA <= 32'(div_reg);
                `LUTX_OFF_IF:     PRDATA <= 32'(flag_reg);
                `LUTX_OFF_STATUS: begin
                    PRDATA[`LUTX_ST_ON]    <= on_reg;
                    PRDATA[`LUTX_ST_DONE]  <= done_reg;
                    PRDATA[`LUTX_ST_LEVEL] <= !full_reg;
                end
                default: PRDATA <= '0;
                endcase
            end
        end
    end
endmodule : lutx_top

// [sim/low_energy_uart_tx_framing_test.sv]
// Purpose: register and frame tests of the serial transmitter
// Assumes: 8 or 8.5 clocks per bit from small divider values
// Notes:   flip frame runs last; receiver model keys on edges
`include "lutx_defines.svh"
module low_energy_uart_tx_framing_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock   = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_line;
    real         rx_p    = 8.0;
    int          rx_n    = 10;
    logic        rx_flip = 1'b0;
    logic [12:0] rx_bits;
    int          rx_count;
    logic [31:0] rd;
    logic        er;
    int          base;
    int          fail_count = 0;
    int          checks     = 0;
    always #20 clock = ~clock;
    lutx_top i_dut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TX_LINE(tx_line));
    lutx_line_rx i_rx (.clock(clock), .line(tx_line), .flip(rx_flip), .period(rx_p),
        .nbits(rx_n), .bits(rx_bits), .count(rx_count));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h expected %h", $time, s, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) begin
            cmp(32'h0, 32'h1, "bus hang");
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string s);
        apb(1'b0, a, 32'h0);
        cmp(rd & m, e, s);
    endtask : rdc
    task automatic wait_rx(input int target, input int limit);
        int n;
        n = 0;
        while (rx_count < target && n < limit) begin
            @(posedge clock);
            n++;
        end
        if (rx_count < target) begin
            cmp(32'h0, 32'h1, "no frame");
            end_of_test();
        end
    endtask : wait_rx
    // expected line levels, start bit in bit 0
    function automatic logic [12:0] frame(input logic [8:0] d, input logic [6:0] c,
                                          output int n);
        logic [12:0] f;
        int          k;
        f    = '1;
        f[0] = 1'b0;
        k    = c[0] ? 10 : 9;
        for (int i = 1; i < k; i++) f[i] = d[i-1];
        if (c[3]) begin
            f[k] = (^d) ^ c[2];
            k++;
        end
        n = k + (c[4] ? 2 : 1);
        return c[5] ? ~f : f;
    endfunction : frame
    task automatic chkf(input logic [8:0] v, input logic [6:0] c);
        logic [12:0] e;
        int          n;
        e = frame(v, c, n);
        cmp(32'(rx_bits) & ((32'h1 << n) - 32'h1), 32'(e) & ((32'h1 << n) - 32'h1), "frame");
    endtask : chkf
    task automatic send(input logic [6:0] c, input logic [8:0] d, input logic x,
                        input logic [31:0] div);
        logic [8:0] v;
        v       = x ? d : {c[0] & c[6], d[7:0]};
        void'(frame(v, c, rx_n));
        rx_p    = 1.0 + real'(div) / 256.0;
        rx_flip = c[5];
        apb(1'b1, `LUTX_OFF_CTRL, {25'h0, c});
        apb(1'b1, `LUTX_OFF_CLKDIV, div);
        apb(1'b1, `LUTX_OFF_CMD, 32'h1);
        apb(1'b1, x ? `LUTX_OFF_TXDATAX : `LUTX_OFF_TXDATA, {23'h0, d});
        wait_rx(rx_count + 1, 300);
        chkf(v, c);
        rd = 32'h0;
        for (int i = 0; i < 12 && !rd[1]; i++) apb(1'b0, `LUTX_OFF_STATUS, 32'h0);
        cmp(rd & 32'h2, 32'h2, "done status");
        rdc(`LUTX_OFF_IF, 32'h1, 32'h1, "done flag");
        apb(1'b1, `LUTX_OFF_IFC, 32'h7);
    endtask : send
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdc(`LUTX_OFF_CTRL, 32'hFFFF_FFFF, 32'h0, "ctrl reset");
        rdc(`LUTX_OFF_STATUS, 32'h3, 32'h0, "status reset");
        rdc(`LUTX_OFF_IF, 32'h7, 32'h0, "flags reset");
        apb(1'b1, `LUTX_OFF_CLKDIV, 32'hFFFF_FFFF);
        rdc(`LUTX_OFF_CLKDIV, 32'hFFFF_FFFF, 32'h0001_FFF8, "divider");
        apb(1'b0, 8'h40, 32'h0);
        cmp({31'h0, er}, 32'h1, "unmapped read");
        $display("register test ends");
        send(7'h00, 9'h0A5, 1'b0, 32'h700);
        send(7'h18, 9'h007, 1'b0, 32'h780);
        send(7'h0C, 9'h007, 1'b0, 32'h700);
        send(7'h41, 9'h03C, 1'b0, 32'h700);
        send(7'h4D, 9'h0C3, 1'b1, 32'h700);
        $display("frame format test ends");
        rx_n = 10;
        apb(1'b1, `LUTX_OFF_CTRL, 32'h0);
        apb(1'b1, `LUTX_OFF_TXDATA, 32'h0);
        base = rx_count;
        repeat (30) @(posedge clock);
        apb(1'b1, `LUTX_OFF_CMD, 32'h3);
        rdc(`LUTX_OFF_STATUS, 32'h1, 32'h0, "off status");
        wait_rx(base + 1, 200);
        cmp({31'h0, tx_line}, 32'h1, "idle after abort");
        apb(1'b1, `LUTX_OFF_TXDATA, 32'h55);
        repeat (150) @(posedge clock);
        cmp(32'(rx_count), 32'(base + 1), "sent while off");
        apb(1'b1, `LUTX_OFF_CMD, 32'h1);
        wait_rx(base + 2, 300);
        chkf(9'h055, 7'h00);
        $display("abort test ends");
        base = rx_count;
        apb(1'b1, `LUTX_OFF_TXDATA, 32'h11);
        rdc(`LUTX_OFF_STATUS, 32'h2, 32'h0, "done cleared");
        apb(1'b1, `LUTX_OFF_TXDATA, 32'h22);
        apb(1'b1, `LUTX_OFF_TXDATA, 32'h33);
        rdc(`LUTX_OFF_IF, 32'h4, 32'h4, "overflow");
        rdc(`LUTX_OFF_STATUS, 32'h4, 32'h0, "buffer full");
        wait_rx(base + 1, 100);
        chkf(9'h011, 7'h00);
        wait_rx(base + 2, 85);
        chkf(9'h022, 7'h00);
        repeat (150) @(posedge clock);
        cmp(32'(rx_count), 32'(base + 2), "dropped word sent");
        rdc(`LUTX_OFF_IF, 32'h2, 32'h2, "buffer level");
        $display("back to back test ends");
        send(7'h20, 9'h081, 1'b0, 32'h700);
        $display("polarity test ends");
        end_of_test();
    end
endmodule : low_energy_uart_tx_framing_test
bind lutx_top lutx_tx_monitor i_mon (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_LINE(TX_LINE));

// [sim/lutx_line_rx.sv]
// Purpose: far-end receiver model on the transmit line
// Assumes: bench sets frame length, period and polarity per frame
// Notes:   one mid-bit sample, no glitch filter unlike real parts
module lutx_line_rx (
    input wire logic        clock,
    input wire logic        line,
    input wire logic        flip,
    input var  real         period,
    input var  int          nbits,
    output logic     [12:0] bits,
    output int              count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;
    int   c;
    initial begin
        bits  = '0;
        count = 0;
        prev  = 1'b0;
        forever begin
            @(posedge clock);
            if (prev === ~flip && line === flip) begin // idle to start edge
                c = 0;
                for (int i = 0; i < nbits; i++) begin // lsb first, then stops
                    while (real'(c) < (real'(i) + 0.5) * period - 1.0) begin
                        @(posedge clock);
                        c++;
                    end
                    bits[i] = line;
                end
                count++;
            end
            prev = line;
        end
    end
endmodule : lutx_line_rx

// [sim/lutx_tx_monitor.sv]
// Purpose: port checks for the serial transmitter
// Assumes: zero-wait APB answers, offsets from the shared header
// Notes:   tracks enable and flip from bus writes
`include "lutx_defines.svh"
module lutx_tx_monitor (
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        TX_LINE
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       on_reg;
    logic       flip_reg;
    logic [1:0] quiet_reg;
    wire logic  setup  = PSEL && !PENABLE;
    wire logic  wr_acc = PSEL && PENABLE && PWRITE && PREADY;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            on_reg   <= 1'b0;
            flip_reg <= 1'b0;
        end else if (wr_acc && PADDR == `LUTX_OFF_CMD) begin
            on_reg <= !PWDATA[1] && (PWDATA[0] || on_reg);
        end else if (wr_acc && PADDR == `LUTX_OFF_CTRL) begin
            flip_reg <= PWDATA[5];
        end
    end
    // settle time after any write; abort and flip land within it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            quiet_reg <= 2'h0;
        end else begin
            quiet_reg <= wr_acc ? 2'h0 : (quiet_reg == 2'h3 ? quiet_reg : quiet_reg + 2'h1);
        end
    end
    AST_READY_AFTER_SETUP: assert property (setup |=> PREADY)
        else $error("no ready in access cycle");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready held two cycles");
    AST_READY_IN_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    AST_ERR_UNMAPPED: assert property (setup && PADDR > `LUTX_OFF_TXDATAX
        |=> PSLVERR && (PWRITE || PRDATA == 32'h0)) else $error("unmapped not refused");
    AST_ERR_ONLY_UNMAPPED: assert property (PSLVERR |->
        $past(PADDR) > `LUTX_OFF_TXDATAX || $past(PADDR[1:0]) != 2'h0)
        else $error("error on mapped address");
    AST_DIV_FIELD: assert property (
        setup && !PWRITE && PADDR == `LUTX_OFF_CLKDIV |=> PRDATA[2:0] == 3'h0
        && PRDATA[31:17] == 15'h0) else $error("divider bits outside field");
    AST_STATUS_ON: assert property (
        setup && !PWRITE && PADDR == `LUTX_OFF_STATUS |=> PRDATA[0] == on_reg)
        else $error("enable status wrong");
    AST_IDLE_WHEN_OFF: assert property (
        !on_reg && quiet_reg == 2'h3 |-> TX_LINE == !flip_reg) else $error("line not idle");
    AST_RESET_IDLE: assert property ($rose(RST_N) |-> TX_LINE)
        else $error("line not idle after reset");
endmodule : lutx_tx_monitor
